// ==== rtl/eee_tx_lpi_pkg.sv ====
package eee_tx_lpi_pkg;

  // Clock and prescaler timing
  localparam int unsigned CLK_PERIOD_PS  = 10000;
  localparam int unsigned HALF_US_PS     = 500000;
  localparam int unsigned HALF_US_CYCLES = HALF_US_PS / CLK_PERIOD_PS;

  // Register byte offsets
  localparam logic [11:0] CTRL_OFF        = 12'h100;
  localparam logic [11:0] INT_STATUS_OFF  = 12'h10C;
  localparam logic [11:0] INT_MASK_OFF    = 12'h110;
  localparam logic [11:0] LPI_STATE_OFF   = 12'h114;
  localparam logic [11:0] ENTRY_DELAY_OFF = 12'h130;
  localparam logic [11:0] EXIT_WAIT_OFF   = 12'h134;

  // Field positions
  localparam int unsigned ENABLE_BIT      = 0;
  localparam int unsigned ENTRY_IRQ_BIT   = 0;
  localparam int unsigned LPI_ACTIVE_BIT  = 0;
  localparam int unsigned TX_HOLD_BIT     = 1;
  localparam int unsigned GIG_FIELD_LSB   = 16;
  localparam int unsigned FAST_FIELD_LSB  = 0;

  // Reset values
  localparam logic [31:0] ENTRY_DELAY_RST = 32'h0000_0000;
  localparam logic [15:0] GIG_WAIT_RST    = 16'h0021;
  localparam logic [15:0] FAST_WAIT_RST   = 16'h001E;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ENTRY_WAIT,
    ST_LPI,
    ST_EXIT_WAIT
  } lpi_state_t;

endpackage : eee_tx_lpi_pkg

// ==== rtl/eee_tx_lpi_timing.sv ====
module eee_tx_lpi_timing #(
  parameter int unsigned ADDR_W         = 12,
  parameter int unsigned HALF_US_CYCLES = eee_tx_lpi_pkg::HALF_US_CYCLES
) (
  input  wire logic              core_clk,         // Core clock, 100 MHz
  input  wire logic              sys_rst,          // Synchronous reset, active high
  input  wire logic              clk_en,           // Freezes all state while low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // Write address
  input  wire logic              s_axi_awvalid,    // Write address valid
  output logic                   s_axi_awready,    // Write address ready
  input  wire logic [31:0]       s_axi_wdata,      // Write data
  input  wire logic [3:0]        s_axi_wstrb,      // Write byte strobes
  input  wire logic              s_axi_wvalid,     // Write data valid
  output logic                   s_axi_wready,     // Write data ready
  output logic [1:0]             s_axi_bresp,      // Write response
  output logic                   s_axi_bvalid,     // Write response valid
  input  wire logic              s_axi_bready,     // Write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,     // Read address
  input  wire logic              s_axi_arvalid,    // Read address valid
  output logic                   s_axi_arready,    // Read address ready
  output logic [31:0]            s_axi_rdata,      // Read data
  output logic [1:0]             s_axi_rresp,      // Read response
  output logic                   s_axi_rvalid,     // Read data valid
  input  wire logic              s_axi_rready,     // Read data ready
  input  wire logic              tx_fifo_empty,    // Transmit FIFO holds no data
  input  wire logic              link_speed_gig,   // Link runs at 1000 Mb/s
  input  wire logic              link_speed_fast,  // Link runs at 100 Mb/s
  input  wire logic              link_full_duplex, // Link is full duplex
  input  wire logic              link_eee_capable, // Both ends negotiated EEE at this speed
  output logic                   tx_lpi_req,       // Low power idle requested toward the PHY
  output logic                   tx_hold,          // Packet start held after idle exit
  output logic                   irq               // Level interrupt
);

  localparam int unsigned AW_HI = ADDR_W - 1;

  function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    sel = (a[AW_HI:2] == off[AW_HI:2]);
  endfunction : sel

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = sel(a, eee_tx_lpi_pkg::CTRL_OFF) || sel(a, eee_tx_lpi_pkg::INT_STATUS_OFF) ||
             sel(a, eee_tx_lpi_pkg::INT_MASK_OFF) || sel(a, eee_tx_lpi_pkg::LPI_STATE_OFF) ||
             sel(a, eee_tx_lpi_pkg::ENTRY_DELAY_OFF) || sel(a, eee_tx_lpi_pkg::EXIT_WAIT_OFF);
  endfunction : mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction : merge

  // Register state
  logic                       energy_saving_enable_q;
  logic                       lpi_entry_irq_flag_q;
  logic                       irq_mask_q;
  logic [31:0]                lpi_entry_delay_count_q;
  logic [15:0]                exit_wait_gig_count_q;
  logic [15:0]                exit_wait_fast_count_q;

  // Bus state
  logic [ADDR_W-1:0]          waddr_q;
  logic [31:0]                wdata_q;
  logic [3:0]                 wstrb_q;
  logic                       wr_fire;
  logic                       rd_fire;
  logic                       sts_read;

  // Timing state
  eee_tx_lpi_pkg::lpi_state_t st_q;
  logic [31:0]                entry_cnt_q;
  logic [15:0]                exit_cnt_q;
  logic                       eligible;
  logic                       entry_set;
  logic                       half_tick;
  logic                       us_tick;
  logic [15:0]                exit_load;
  logic                       exit_tick;

  us_prescaler #(
    .HALF_US_CYCLES (HALF_US_CYCLES)
  ) u_prescaler (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .half_tick (half_tick),
    .us_tick   (us_tick)
  );

  // Write channel: address and data taken independently, then one write
  assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign sts_read = rd_fire & sel(s_axi_araddr, eee_tx_lpi_pkg::INT_STATUS_OFF);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= eee_tx_lpi_pkg::RESP_OKAY;
      waddr_q       <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_q       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(waddr_q) ? eee_tx_lpi_pkg::RESP_OKAY
                                        : eee_tx_lpi_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      energy_saving_enable_q  <= 1'b0;
      irq_mask_q              <= 1'b0;
      lpi_entry_delay_count_q <= eee_tx_lpi_pkg::ENTRY_DELAY_RST;
      exit_wait_gig_count_q   <= eee_tx_lpi_pkg::GIG_WAIT_RST;
      exit_wait_fast_count_q  <= eee_tx_lpi_pkg::FAST_WAIT_RST;
    end else if (clk_en && wr_fire) begin
      if (sel(waddr_q, eee_tx_lpi_pkg::CTRL_OFF) && wstrb_q[0]) begin
        energy_saving_enable_q <= wdata_q[eee_tx_lpi_pkg::ENABLE_BIT];
      end
      if (sel(waddr_q, eee_tx_lpi_pkg::INT_MASK_OFF) && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[eee_tx_lpi_pkg::ENTRY_IRQ_BIT];
      end
      if (sel(waddr_q, eee_tx_lpi_pkg::ENTRY_DELAY_OFF)) begin
        lpi_entry_delay_count_q <= merge(lpi_entry_delay_count_q, wdata_q, wstrb_q);
      end
      if (sel(waddr_q, eee_tx_lpi_pkg::EXIT_WAIT_OFF)) begin
        {exit_wait_gig_count_q, exit_wait_fast_count_q} <=
          merge({exit_wait_gig_count_q, exit_wait_fast_count_q}, wdata_q, wstrb_q);
      end
    end
  end

  // Read channel: one-cycle answer after the address is taken
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= eee_tx_lpi_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= mapped(s_axi_araddr) ? eee_tx_lpi_pkg::RESP_OKAY
                                              : eee_tx_lpi_pkg::RESP_SLVERR;
        s_axi_rdata   <= '0;
        if (sel(s_axi_araddr, eee_tx_lpi_pkg::CTRL_OFF)) begin
          s_axi_rdata[eee_tx_lpi_pkg::ENABLE_BIT] <= energy_saving_enable_q;
        end else if (sel(s_axi_araddr, eee_tx_lpi_pkg::INT_STATUS_OFF)) begin
          s_axi_rdata[eee_tx_lpi_pkg::ENTRY_IRQ_BIT] <= lpi_entry_irq_flag_q;
        end else if (sel(s_axi_araddr, eee_tx_lpi_pkg::INT_MASK_OFF)) begin
          s_axi_rdata[eee_tx_lpi_pkg::ENTRY_IRQ_BIT] <= irq_mask_q;
        end else if (sel(s_axi_araddr, eee_tx_lpi_pkg::LPI_STATE_OFF)) begin
          s_axi_rdata[eee_tx_lpi_pkg::LPI_ACTIVE_BIT] <= tx_lpi_req;
          s_axi_rdata[eee_tx_lpi_pkg::TX_HOLD_BIT]    <= tx_hold;
        end else if (sel(s_axi_araddr, eee_tx_lpi_pkg::ENTRY_DELAY_OFF)) begin
          s_axi_rdata <= lpi_entry_delay_count_q;
        end else if (sel(s_axi_araddr, eee_tx_lpi_pkg::EXIT_WAIT_OFF)) begin
          s_axi_rdata <= {exit_wait_gig_count_q, exit_wait_fast_count_q};
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Eligibility gate for every idle request
  assign eligible = energy_saving_enable_q & link_full_duplex & link_eee_capable &
                    (link_speed_gig | link_speed_fast);
  assign exit_load = link_speed_gig ? exit_wait_gig_count_q : exit_wait_fast_count_q;
  assign exit_tick = link_speed_gig ? half_tick : us_tick;

  // Entry into idle, either immediately for a zero delay or after the count runs out
  assign entry_set = clk_en && eligible && tx_fifo_empty &&
                     (((st_q == eee_tx_lpi_pkg::ST_IDLE) && (lpi_entry_delay_count_q == '0)) ||
                      ((st_q == eee_tx_lpi_pkg::ST_ENTRY_WAIT) && (entry_cnt_q == '0) &&
                       us_tick));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q        <= eee_tx_lpi_pkg::ST_IDLE;
      entry_cnt_q <= '0;
      exit_cnt_q  <= '0;
      tx_lpi_req  <= 1'b0;
      tx_hold     <= 1'b0;
    end else if (clk_en) begin
      case (st_q)
        eee_tx_lpi_pkg::ST_IDLE: begin
          if (eligible && tx_fifo_empty) begin
            if (lpi_entry_delay_count_q == '0) begin
              st_q       <= eee_tx_lpi_pkg::ST_LPI;
              tx_lpi_req <= 1'b1;
            end else begin
              st_q        <= eee_tx_lpi_pkg::ST_ENTRY_WAIT;
              entry_cnt_q <= lpi_entry_delay_count_q;
            end
          end
        end
        eee_tx_lpi_pkg::ST_ENTRY_WAIT: begin
          if (!eligible || !tx_fifo_empty) begin
            st_q <= eee_tx_lpi_pkg::ST_IDLE;
          end else if (us_tick && (entry_cnt_q == '0)) begin
            // Expire on the tick after zero so the wait never falls short of the count
            st_q       <= eee_tx_lpi_pkg::ST_LPI;
            tx_lpi_req <= 1'b1;
          end else if (us_tick) begin
            entry_cnt_q <= entry_cnt_q - 1'b1;
          end
        end
        eee_tx_lpi_pkg::ST_LPI: begin
          if (!eligible || !tx_fifo_empty) begin
            st_q       <= eee_tx_lpi_pkg::ST_EXIT_WAIT;
            tx_lpi_req <= 1'b0;
            tx_hold    <= 1'b1;
            exit_cnt_q <= exit_load;
          end
        end
        eee_tx_lpi_pkg::ST_EXIT_WAIT: begin
          if (exit_tick && (exit_cnt_q == '0)) begin
            st_q    <= eee_tx_lpi_pkg::ST_IDLE;
            tx_hold <= 1'b0;
          end else if (exit_tick) begin
            exit_cnt_q <= exit_cnt_q - 1'b1;
          end
        end
        default: begin
          st_q       <= eee_tx_lpi_pkg::ST_IDLE;
          tx_lpi_req <= 1'b0;
          tx_hold    <= 1'b0;
        end
      endcase
    end
  end

  // Sticky status, cleared by reading; a new event in the read cycle wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lpi_entry_irq_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (entry_set) begin
        lpi_entry_irq_flag_q <= 1'b1;
      end else if (sts_read) begin
        lpi_entry_irq_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= lpi_entry_irq_flag_q & irq_mask_q;
    end
  end

  property p_disabled_no_idle;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !eligible |=> (st_q != eee_tx_lpi_pkg::ST_ENTRY_WAIT) &&
                            (st_q != eee_tx_lpi_pkg::ST_LPI) && !tx_lpi_req;
  endproperty
  a_disabled_no_idle: assert property (p_disabled_no_idle)
    else $error("idle pursued while not eligible");

  property p_expiry_sets_flag;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && eligible && tx_fifo_empty && (st_q == eee_tx_lpi_pkg::ST_ENTRY_WAIT) &&
    (entry_cnt_q == '0) && us_tick |=> tx_lpi_req && lpi_entry_irq_flag_q;
  endproperty
  a_expiry_sets_flag: assert property (p_expiry_sets_flag)
    else $error("expired delay did not start idle and set the flag");

  property p_zero_delay;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && eligible && tx_fifo_empty && (st_q == eee_tx_lpi_pkg::ST_IDLE) &&
    (lpi_entry_delay_count_q == '0) |=> (st_q == eee_tx_lpi_pkg::ST_LPI) && tx_lpi_req;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero delay did not start idle at once");

  property p_restart;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && (st_q == eee_tx_lpi_pkg::ST_ENTRY_WAIT) && !tx_fifo_empty
    |=> (st_q == eee_tx_lpi_pkg::ST_IDLE);
  endproperty
  a_restart: assert property (p_restart)
    else $error("delay timer not restarted on traffic");

  property p_entry_load;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && eligible && tx_fifo_empty && (st_q == eee_tx_lpi_pkg::ST_IDLE) &&
    (lpi_entry_delay_count_q != '0) |=> (entry_cnt_q == $past(lpi_entry_delay_count_q));
  endproperty
  a_entry_load: assert property (p_entry_load)
    else $error("entry delay not loaded from register");

  property p_entry_tick_only;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !us_tick && (st_q == eee_tx_lpi_pkg::ST_ENTRY_WAIT)
    |=> $stable(entry_cnt_q);
  endproperty
  a_entry_tick_only: assert property (p_entry_tick_only)
    else $error("entry counter moved without a microsecond tick");

  property p_exit_load;
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && (st_q == eee_tx_lpi_pkg::ST_LPI) && !tx_fifo_empty
    |=> tx_hold && !tx_lpi_req &&
        (exit_cnt_q == ($past(link_speed_gig) ? exit_wait_gig_count_q
                                              : exit_wait_fast_count_q));
  endproperty
  a_exit_load: assert property (p_exit_load)
    else $error("exit wait not loaded for the link speed");

  property p_hold_while_counting;
    @(posedge core_clk) disable iff (sys_rst)
    (st_q == eee_tx_lpi_pkg::ST_EXIT_WAIT) && (exit_cnt_q != '0) |=> tx_hold;
  endproperty
  a_hold_while_counting: assert property (p_hold_while_counting)
    else $error("transmit released before exit wait ended");

  property p_tick_spacing;
    // A frozen cycle holds the tick, so spacing is judged only while enabled
    @(posedge core_clk) disable iff (sys_rst || !clk_en)
    us_tick |=> !us_tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("microsecond ticks too close together");

endmodule : eee_tx_lpi_timing

// ==== rtl/us_prescaler.sv ====
module us_prescaler #(
  parameter int unsigned HALF_US_CYCLES = eee_tx_lpi_pkg::HALF_US_CYCLES
) (
  input  wire logic core_clk,   // Core clock
  input  wire logic sys_rst,    // Synchronous reset, active high
  input  wire logic clk_en,     // Freezes the prescaler while low
  output logic      half_tick,  // One-cycle pulse every 0.5 us
  output logic      us_tick     // One-cycle pulse every 1 us
);

  localparam int unsigned CW = (HALF_US_CYCLES > 1) ? $clog2(HALF_US_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_US_CYCLES - 1);

  logic [CW-1:0] div_q;
  logic          phase_q;

  // Free running, so a delay started mid-period can run up to one tick long
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q     <= '0;
      phase_q   <= 1'b0;
      half_tick <= 1'b0;
      us_tick   <= 1'b0;
    end else if (clk_en) begin
      half_tick <= 1'b0;
      us_tick   <= 1'b0;
      if (div_q == LAST) begin
        div_q     <= '0;
        phase_q   <= ~phase_q;
        half_tick <= 1'b1;
        us_tick   <= phase_q;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end

endmodule : us_prescaler

// ==== verif/phy_link_model.sv ====
module phy_link_model (
  input  wire logic       core_clk,         // Core clock
  input  wire logic [1:0] link_mode,        // 0 gig FD, 1 fast FD, 2 half duplex, 3 no EEE
  input  wire logic       tx_lpi_req,       // Idle request from the MAC
  input  wire logic       tx_hold,          // MAC holds packet start
  output logic            link_speed_gig,   // Resolved 1000 Mb/s
  output logic            link_speed_fast,  // Resolved 100 Mb/s
  output logic            link_full_duplex, // Resolved full duplex
  output logic            link_eee_capable, // Both ends negotiated EEE
  output logic            phy_quiet         // PHY has entered its quiet state
);
  timeunit 1ns;
  timeprecision 1ps;
  // Negotiated state only changes when the bench asks for a new link mode
  assign link_speed_gig   = (link_mode == 2'h0);
  assign link_speed_fast  = (link_mode != 2'h0);
  assign link_full_duplex = (link_mode != 2'h2);
  assign link_eee_capable = (link_mode != 2'h3);
  always_ff @(posedge core_clk) begin
    phy_quiet <= tx_lpi_req & ~tx_hold;
  end
endmodule : phy_link_model

// ==== verif/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, tx_fifo_empty = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  // Response ready stays high, so every answer is taken at the edge it is seen
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, link_mode = 2'h0;
  logic link_speed_gig, link_speed_fast, link_full_duplex, link_eee_capable;
  logic tx_lpi_req, tx_hold, irq;
  logic [31:0] rd;
  logic [1:0]  rr, rb;
  int failures = 0, n_checks = 0, cyc = 0, n;

  always #5 core_clk = ~core_clk;

  eee_tx_lpi_timing #(.HALF_US_CYCLES(5)) u_dut (.*);
  phy_link_model u_phy (.core_clk(core_clk), .link_mode(link_mode), .tx_lpi_req(tx_lpi_req),
    .tx_hold(tx_hold), .link_speed_gig(link_speed_gig), .link_speed_fast(link_speed_fast),
    .link_full_duplex(link_full_duplex), .link_eee_capable(link_eee_capable), .phy_quiet());

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask : chk_rng

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    rb = s_axi_bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a);
    int k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : axi_rd

  // Returns the cycles spent until the chosen output reaches the level
  task automatic wait_on(input bit hold, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (((hold ? tx_hold : tx_lpi_req) !== v) && cnt < lim) begin
      @(posedge core_clk);
      cnt++;
    end
  endtask : wait_on

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // Whole run is near 850 cycles; the ceiling leaves ample margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    axi_rd(12'h130);
    chk(rd, 32'h0000_0000);
    axi_rd(12'h134);
    chk(rd, 32'h0021_001E);
    axi_rd(12'h1F0);
    chk({30'h0, rr}, 32'h2);
    chk(rd, 32'h0);
    axi_wr(12'h1F0, 32'hFFFF_FFFF);
    chk({30'h0, rb}, 32'h2);
    $display("test reset values done");
    repeat (60) @(posedge core_clk);
    chk({31'h0, tx_lpi_req}, 32'h0);
    $display("test disabled done");
    axi_wr(12'h110, 32'h1);
    chk({30'h0, rb}, 32'h0);
    axi_wr(12'h100, 32'h1);
    wait_on(1'b0, 1'b1, 20, n);
    chk_rng(n, 0, 3);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h1);
    axi_rd(12'h10C);
    chk(rd, 32'h1);
    axi_rd(12'h10C);
    chk(rd, 32'h0);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    axi_rd(12'h114);
    chk(rd, 32'h1);
    $display("test zero delay done");
    tx_fifo_empty <= 1'b0;
    wait_on(1'b1, 1'b1, 10, n);
    chk_rng(n, 1, 3);
    // Frozen cycles must not count toward the exit wait
    clk_en <= 1'b0;
    repeat (50) @(posedge core_clk);
    clk_en <= 1'b1;
    wait_on(1'b1, 1'b0, 400, n);
    chk_rng(n, 160, 175);
    $display("test gig exit done");
    axi_wr(12'h100, 32'h0);
    link_mode <= 2'h1;
    axi_wr(12'h130, 32'h3);
    axi_rd(12'h130);
    chk(rd, 32'h3);
    axi_wr(12'h100, 32'h1);
    tx_fifo_empty <= 1'b1;
    repeat (20) @(posedge core_clk);
    tx_fifo_empty <= 1'b0;
    @(posedge core_clk);
    tx_fifo_empty <= 1'b1;
    wait_on(1'b0, 1'b1, 200, n);
    chk_rng(n, 30, 45);
    tx_fifo_empty <= 1'b0;
    wait_on(1'b1, 1'b1, 10, n);
    wait_on(1'b1, 1'b0, 600, n);
    chk_rng(n, 290, 315);
    $display("test fast entry and exit done");
    link_mode <= 2'h2;
    tx_fifo_empty <= 1'b1;
    repeat (80) @(posedge core_clk);
    chk({31'h0, tx_lpi_req}, 32'h0);
    link_mode <= 2'h3;
    repeat (80) @(posedge core_clk);
    chk({31'h0, tx_lpi_req}, 32'h0);
    $display("test ineligible link done");
    conclude();
  end
endmodule : tb
